// file: shared/arlc_pkg.sv
// Package: register map, field layout, reset values and widths of the result limit checker
package arlc_pkg;

  // Bus and datapath widths
  localparam int ADDR_W     = 14;
  localparam int DATA_W     = 32;
  localparam int RESULT_W   = 16;
  localparam int GAIN_W     = 15;
  localparam int GAIN_FRAC  = 14;
  localparam int EVENT_W    = 3;

  // Register byte offsets
  localparam logic [13:0] OFF_LOW_THRESHOLD   = 14'h20a8;
  localparam logic [13:0] OFF_LOW_HYSTERESIS  = 14'h20ac;
  localparam logic [13:0] OFF_HIGH_THRESHOLD  = 14'h20b0;
  localparam logic [13:0] OFF_HIGH_HYSTERESIS = 14'h20b4;
  localparam logic [13:0] OFF_STEP_LIMIT      = 14'h20b8;
  localparam logic [13:0] OFF_TEMP_GAIN_CAL   = 14'h2238;
  localparam logic [13:0] OFF_IRQ_STATUS      = 14'h2300;
  localparam logic [13:0] OFF_IRQ_ENABLE      = 14'h2304;
  localparam logic [13:0] OFF_IRQ_CLEAR       = 14'h2308;
  localparam logic [13:0] OFF_LIVE_STATE      = 14'h230c;
  localparam logic [13:0] OFF_LAST_RESULT     = 14'h2310;

  // Event bit positions in status, enable, clear and live state
  localparam int BIT_UNDER_RANGE = 0;
  localparam int BIT_OVER_RANGE  = 1;
  localparam int BIT_STEP_ERROR  = 2;

  // Reset values
  localparam logic [15:0] RST_THRESHOLD = 16'h0000;
  localparam logic [14:0] RST_TEMP_GAIN = 15'h4000;
  localparam logic [2:0]  RST_EVENTS    = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : arlc_pkg

// file: core/arlc_gain_mul.sv
// Gain correction stage for temperature-sensor conversions
`timescale 1ns/1ns
module arlc_gain_mul #(
  parameter int DW = 16,
  parameter int GW = 15,
  parameter int FW = 14
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          in_valid,
  input  wire logic [DW-1:0] in_data,
  input  wire logic          in_is_temp,
  input  wire logic [GW-1:0] gain,
  output logic               out_valid,
  output logic [DW-1:0]      out_data
);

  logic [DW+GW-1:0] product;
  logic [DW:0]      scaled;
  logic [DW-1:0]    corrected;
  logic             next_out_valid;
  logic [DW-1:0]    next_out_data;

  // Code/2^14 factor; code zero gives zero, 0x7fff just under two
  always_comb begin
    product   = in_data * gain;
    scaled    = product[DW+FW:FW];
    corrected = scaled[DW] ? {DW{1'b1}} : scaled[DW-1:0];       // Saturate, never wrap past full scale
    next_out_valid = in_valid;
    next_out_data  = out_data;
    if (in_valid) begin
      next_out_data = in_is_temp ? corrected : in_data;
    end
  end

  // Result register, one cycle of latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

endmodule : arlc_gain_mul

// file: core/arlc_top.sv
// Result limit checker: gain correction, range and step checks, AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module arlc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        result_valid,
  input  wire logic [15:0] result_data,
  input  wire logic        result_is_temp,
  output logic             conversion_valid,
  output logic [15:0]      conversion_result,
  output logic             irq,
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Software visible configuration
  logic [15:0] low_limit_value;
  logic [15:0] low_release_margin;
  logic [15:0] high_limit_value;
  logic [15:0] high_release_margin;
  logic [15:0] step_limit_value;
  logic [14:0] temp_gain_value;
  logic [2:0]  irq_enable;
  logic [2:0]  irq_status;

  // Checker state
  logic        under_range_flag;
  logic        over_range_flag;
  logic [15:0] prev_result;
  logic        prev_seen;

  // Write channel state
  logic        aw_held;
  logic [13:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Corrected result from the gain stage
  logic        corr_valid;
  logic [15:0] corr_data;

  // Next values
  logic [15:0] next_low_limit_value;
  logic [15:0] next_low_release_margin;
  logic [15:0] next_high_limit_value;
  logic [15:0] next_high_release_margin;
  logic [15:0] next_step_limit_value;
  logic [14:0] next_temp_gain_value;
  logic [2:0]  next_irq_enable;
  logic [2:0]  next_irq_status;
  logic        next_under_range_flag;
  logic        next_over_range_flag;
  logic [15:0] next_prev_result;
  logic        next_prev_seen;
  logic        next_conversion_valid;
  logic [15:0] next_conversion_result;
  logic        next_aw_held;
  logic [13:0] next_aw_addr;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Helper terms
  logic        wr_fire;
  logic        wr_hit;
  logic [2:0]  clear_mask;
  logic [2:0]  events;
  logic [16:0] low_release_sum;
  logic [15:0] low_release_bound;
  logic [15:0] high_release_bound;
  logic [15:0] step_diff;
  logic        step_event;
  logic [31:0] rd_word;
  logic        rd_hit;

  // Byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0]  = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // Gain correction stage
  arlc_gain_mul #(
    .DW (arlc_pkg::RESULT_W),
    .GW (arlc_pkg::GAIN_W),
    .FW (arlc_pkg::GAIN_FRAC)
  ) u_gain (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .in_valid   (result_valid),
    .in_data    (result_data),
    .in_is_temp (result_is_temp),
    .gain       (temp_gain_value),
    .out_valid  (corr_valid),
    .out_data   (corr_data)
  );

  // Handshake readies; one write and one read outstanding at most
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Level interrupt from enabled sticky bits
  assign irq = |(irq_status & irq_enable);

  // Release bounds saturate at the code range ends
  always_comb begin
    low_release_sum    = {1'b0, low_limit_value} + {1'b0, low_release_margin};
    low_release_bound  = low_release_sum[16] ? 16'hffff : low_release_sum[15:0];
    high_release_bound = (high_limit_value >= high_release_margin) ?
                         high_limit_value - high_release_margin : 16'h0000;
    step_diff          = (corr_data >= prev_result) ? corr_data - prev_result
                                                    : prev_result - corr_data;
  end

  // Range flags with hysteresis and step detection
  always_comb begin
    next_under_range_flag  = under_range_flag;
    next_over_range_flag   = over_range_flag;
    next_prev_result       = prev_result;
    next_prev_seen         = prev_seen;
    next_conversion_valid  = corr_valid;
    next_conversion_result = conversion_result;
    step_event             = 1'b0;
    if (corr_valid) begin
      next_conversion_result = corr_data;
      if (corr_data < low_limit_value) begin
        next_under_range_flag = 1'b1;
      end else if (corr_data > low_release_bound) begin
        next_under_range_flag = 1'b0;
      end
      if (corr_data > high_limit_value) begin
        next_over_range_flag = 1'b1;
      end else if (corr_data < high_release_bound) begin
        next_over_range_flag = 1'b0;
      end
      step_event       = prev_seen && (step_diff > step_limit_value);
      next_prev_result = corr_data;
      next_prev_seen   = 1'b1;
    end
  end

  // Events raised per result while a flag holds; a step is a single event
  always_comb begin
    events = '0;
    events[arlc_pkg::BIT_UNDER_RANGE] = corr_valid && next_under_range_flag;
    events[arlc_pkg::BIT_OVER_RANGE]  = corr_valid && next_over_range_flag;
    events[arlc_pkg::BIT_STEP_ERROR]  = step_event;
  end

  // Register write path; address and data may arrive in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_fire = aw_held && w_held && !s_axi_bvalid;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  // Register updates from a completed write
  always_comb begin
    next_low_limit_value     = low_limit_value;
    next_low_release_margin  = low_release_margin;
    next_high_limit_value    = high_limit_value;
    next_high_release_margin = high_release_margin;
    next_step_limit_value    = step_limit_value;
    next_temp_gain_value     = temp_gain_value;
    next_irq_enable          = irq_enable;
    clear_mask               = '0;
    wr_hit                   = 1'b1;
    if (wr_fire) begin
      unique case (aw_addr)
        arlc_pkg::OFF_LOW_THRESHOLD:   next_low_limit_value = merge16(low_limit_value, w_data, w_strb);
        arlc_pkg::OFF_LOW_HYSTERESIS:  next_low_release_margin = merge16(low_release_margin, w_data, w_strb);
        arlc_pkg::OFF_HIGH_THRESHOLD:  next_high_limit_value = merge16(high_limit_value, w_data, w_strb);
        arlc_pkg::OFF_HIGH_HYSTERESIS: next_high_release_margin = merge16(high_release_margin, w_data, w_strb);
        arlc_pkg::OFF_STEP_LIMIT:      next_step_limit_value = merge16(step_limit_value, w_data, w_strb);
        arlc_pkg::OFF_TEMP_GAIN_CAL: begin
          next_temp_gain_value = 15'(merge16({1'b0, temp_gain_value}, w_data, w_strb));  // Bit 15 reserved
        end
        arlc_pkg::OFF_IRQ_ENABLE: begin
          if (w_strb[0]) next_irq_enable = w_data[2:0];
        end
        arlc_pkg::OFF_IRQ_CLEAR: begin
          if (w_strb[0]) clear_mask = w_data[2:0];
        end
        arlc_pkg::OFF_IRQ_STATUS, arlc_pkg::OFF_LIVE_STATE, arlc_pkg::OFF_LAST_RESULT: begin
          wr_hit = 1'b1;                                        // Read-only, write ignored
        end
        default: wr_hit = 1'b0;
      endcase
    end
    // A new event beats a clear in the same cycle
    next_irq_status = (irq_status & ~clear_mask) | events;
  end

  // Write response
  always_comb begin
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_hit ? arlc_pkg::RESP_OKAY : arlc_pkg::RESP_SLVERR;
    end
  end

  // Read decode; unmapped addresses answer with zero and an error
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      arlc_pkg::OFF_LOW_THRESHOLD:   rd_word[15:0] = low_limit_value;
      arlc_pkg::OFF_LOW_HYSTERESIS:  rd_word[15:0] = low_release_margin;
      arlc_pkg::OFF_HIGH_THRESHOLD:  rd_word[15:0] = high_limit_value;
      arlc_pkg::OFF_HIGH_HYSTERESIS: rd_word[15:0] = high_release_margin;
      arlc_pkg::OFF_STEP_LIMIT:      rd_word[15:0] = step_limit_value;
      arlc_pkg::OFF_TEMP_GAIN_CAL:   rd_word[14:0] = temp_gain_value;
      arlc_pkg::OFF_IRQ_STATUS:      rd_word[2:0]  = irq_status;
      arlc_pkg::OFF_IRQ_ENABLE:      rd_word[2:0]  = irq_enable;
      arlc_pkg::OFF_IRQ_CLEAR:       rd_word       = '0;        // Write-only, reads zero
      arlc_pkg::OFF_LIVE_STATE:      rd_word[1:0]  = {over_range_flag, under_range_flag};
      arlc_pkg::OFF_LAST_RESULT:     rd_word[15:0] = conversion_result;
      default:                       rd_hit        = 1'b0;
    endcase
  end

  // Read data channel
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? arlc_pkg::RESP_OKAY : arlc_pkg::RESP_SLVERR;
    end
  end

  // Configuration and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_limit_value     <= arlc_pkg::RST_THRESHOLD;
      low_release_margin  <= arlc_pkg::RST_THRESHOLD;
      high_limit_value    <= arlc_pkg::RST_THRESHOLD;
      high_release_margin <= arlc_pkg::RST_THRESHOLD;
      step_limit_value    <= arlc_pkg::RST_THRESHOLD;
      temp_gain_value     <= arlc_pkg::RST_TEMP_GAIN;
      irq_enable          <= arlc_pkg::RST_EVENTS;
      irq_status          <= arlc_pkg::RST_EVENTS;
    end else begin
      low_limit_value     <= next_low_limit_value;
      low_release_margin  <= next_low_release_margin;
      high_limit_value    <= next_high_limit_value;
      high_release_margin <= next_high_release_margin;
      step_limit_value    <= next_step_limit_value;
      temp_gain_value     <= next_temp_gain_value;
      irq_enable          <= next_irq_enable;
      irq_status          <= next_irq_status;
    end
  end

  // Checker state; the first result after reset has no predecessor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      under_range_flag  <= 1'b0;
      over_range_flag   <= 1'b0;
      prev_result       <= '0;
      prev_seen         <= 1'b0;
      conversion_valid  <= 1'b0;
      conversion_result <= '0;
    end else begin
      under_range_flag  <= next_under_range_flag;
      over_range_flag   <= next_over_range_flag;
      prev_result       <= next_prev_result;
      prev_seen         <= next_prev_seen;
      conversion_valid  <= next_conversion_valid;
      conversion_result <= next_conversion_result;
    end
  end

  // Bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= arlc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= arlc_pkg::RESP_OKAY;
    end else begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

endmodule : arlc_top

// file: verif/arlc_result_src.sv
// Model of the conversion source that feeds the result port
`timescale 1ns/1ns
module arlc_result_src (
  input  wire logic   aclk,
  output logic        result_valid,
  output logic [15:0] result_data,
  output logic        result_is_temp
);
  // Idle at time zero so nothing is taken during reset
  initial begin
    result_valid = 1'b0;
    result_data = 16'h0000;
    result_is_temp = 1'b0;
  end

  // One result per call; released lines are inverted so stale codes never pass for live ones
  task automatic send(input logic [15:0] d, input logic t);
    result_data <= d;
    result_is_temp <= t;
    result_valid <= 1'b1;
    @(posedge aclk);
    result_valid <= 1'b0;
    result_data <= ~d;
    result_is_temp <= ~t;
    repeat (2) @(posedge aclk);
  endtask : send
endmodule : arlc_result_src

// file: verif/arlc_props.sv
// Port-level assertion checker for the result limit checker
`timescale 1ns/1ns
module arlc_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        result_valid,
  input wire logic [15:0] result_data,
  input wire logic        result_is_temp,
  input wire logic        conversion_valid,
  input wire logic [15:0] conversion_result,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Result path: two stages between a taken code and its checked output
  sequence res_plain_s;
    result_valid && !result_is_temp;
  endsequence
  sequence res_out_s;
    ##2 conversion_valid;
  endsequence

  conv_latency_a: assert property (result_valid |-> res_out_s)
    else $error("checked result did not follow input");
  conv_source_a: assert property (conversion_valid |-> $past(result_valid, 2))
    else $error("checked result without input");
  plain_pass_a: assert property (res_plain_s |-> ##2 conversion_result == $past(result_data, 2))
    else $error("non-temperature result altered");

  // Register bus handshakes; address and data sit one cycle in holding registers before the response
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  write_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule : arlc_props

// file: verif/testbench.sv
// Self-checking bench for the result limit checker
`timescale 1ns/1ns
module testbench;
  logic        aclk, aresetn, result_valid, result_is_temp, conversion_valid, irq;
  logic [15:0] result_data, conversion_result;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          bad_count = 0;
  int          checks = 0;
  logic [15:0] gc [7] = '{16'h4000, 16'h2000, 16'h0000, 16'h4001, 16'h7fff, 16'h0001, 16'h3fff};

  arlc_top dut_u (.aclk, .aresetn, .result_valid, .result_data, .result_is_temp, .conversion_valid,
    .conversion_result, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  arlc_result_src src_u (.aclk, .result_valid, .result_data, .result_is_temp);

  always #4 aclk = ~aclk;

  task automatic finish_test;
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (n == 50) begin
      bad_count++;
      finish_test();
    end
  endtask : wr

  // Read: rready comes one cycle after data shows, exercising the hold
  task automatic rd(input logic [13:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    rdv = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n == 50) begin
      bad_count++;
      finish_test();
    end
  endtask : rd

  task automatic rchk(input logic [13:0] a, input logic [31:0] exp);
    rd(a);
    chk("register", rdv, exp);
  endtask : rchk

  // Plain-channel result, then the live range flags
  task automatic rs(input logic [15:0] d, input logic [31:0] exp);
    src_u.send(d, 1'b0);
    rchk(arlc_pkg::OFF_LIVE_STATE, exp);
  endtask : rs

  // Expected temperature result: unsigned code over 2^14, saturated
  function automatic logic [15:0] gx(input logic [15:0] d, input logic [15:0] c);
    logic [31:0] p;
    p = ({16'h0000, d} * {16'h0000, c}) >> 14;
    return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction : gx

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 14'h0000;
    s_axi_araddr = 14'h0000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and bus access
    for (int i = 0; i < 5; i++) rchk(14'h20a8 + 14'(4 * i), 32'h00000000);
    rchk(arlc_pkg::OFF_TEMP_GAIN_CAL, 32'h00004000);
    rd(14'h2000);
    chk("unmapped response", 32'(rresp), 32'(arlc_pkg::RESP_SLVERR));
    wr(14'h2000, 32'h00000001);
    chk("unmapped write response", 32'(wresp), 32'(arlc_pkg::RESP_SLVERR));
    wr(arlc_pkg::OFF_STEP_LIMIT, 32'h00001234);
    rchk(arlc_pkg::OFF_STEP_LIMIT, 32'h00001234);
    wr(arlc_pkg::OFF_STEP_LIMIT, 32'h0000ffff);
    // Every listed gain code on a temperature conversion
    for (int i = 0; i < 7; i++) begin
      wr(arlc_pkg::OFF_TEMP_GAIN_CAL, {16'h0000, gc[i]});
      src_u.send(16'hc000, 1'b1);
      chk("gain result", 32'(conversion_result), 32'(gx(16'hc000, gc[i])));
    end
    src_u.send(16'hc000, 1'b0);
    chk("plain result", 32'(conversion_result), 32'h0000c000);
    // Range flags with hysteresis
    wr(arlc_pkg::OFF_LOW_THRESHOLD, 32'h00000100);
    wr(arlc_pkg::OFF_LOW_HYSTERESIS, 32'h00000010);
    wr(arlc_pkg::OFF_HIGH_THRESHOLD, 32'h00001000);
    wr(arlc_pkg::OFF_HIGH_HYSTERESIS, 32'h00000020);
    rs(16'h00ff, 32'h1);
    rs(16'h0110, 32'h1);
    rs(16'h0111, 32'h0);
    rs(16'h1000, 32'h0);
    rs(16'h1001, 32'h2);
    rs(16'h0fe0, 32'h2);
    rs(16'h0fdf, 32'h0);
    // Bounds saturate instead of wrapping
    wr(arlc_pkg::OFF_HIGH_THRESHOLD, 32'h0000ffff);
    wr(arlc_pkg::OFF_LOW_THRESHOLD, 32'h0000fff8);
    rs(16'hfff0, 32'h1);
    rs(16'hffff, 32'h1);
    wr(arlc_pkg::OFF_LOW_THRESHOLD, 32'h00000000);
    wr(arlc_pkg::OFF_LOW_HYSTERESIS, 32'h00000000);
    wr(arlc_pkg::OFF_HIGH_THRESHOLD, 32'h00000008);
    wr(arlc_pkg::OFF_HIGH_HYSTERESIS, 32'h00000010);
    rs(16'h0009, 32'h2);
    rs(16'h0000, 32'h2);
    // Interrupt: masked, enabled, cleared; status is read-only
    wr(arlc_pkg::OFF_IRQ_ENABLE, 32'h00000000);
    chk("masked irq", 32'(irq), 32'h0);
    wr(arlc_pkg::OFF_IRQ_ENABLE, 32'h00000007);
    chk("enabled irq", 32'(irq), 32'h1);
    wr(arlc_pkg::OFF_IRQ_CLEAR, 32'h00000007);
    chk("cleared irq", 32'(irq), 32'h0);
    wr(arlc_pkg::OFF_IRQ_STATUS, 32'h00000007);
    chk("read-only write response", 32'(wresp), 32'(arlc_pkg::RESP_OKAY));
    rchk(arlc_pkg::OFF_IRQ_STATUS, 32'h00000000);
    // Step check at the limit and one past it
    wr(arlc_pkg::OFF_HIGH_THRESHOLD, 32'h0000ffff);
    wr(arlc_pkg::OFF_STEP_LIMIT, 32'h00000010);
    src_u.send(16'h0500, 1'b0);
    wr(arlc_pkg::OFF_IRQ_CLEAR, 32'h00000007);
    src_u.send(16'h0510, 1'b0);
    rchk(arlc_pkg::OFF_IRQ_STATUS, 32'h00000000);
    src_u.send(16'h0521, 1'b0);
    rchk(arlc_pkg::OFF_IRQ_STATUS, 32'h00000004);
    chk("step irq", 32'(irq), 32'h1);
    // Reset in mid-run: settings, sticky bits and interrupt return to rest
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("irq after reset", 32'(irq), 32'h0);
    rchk(arlc_pkg::OFF_TEMP_GAIN_CAL, 32'h00004000);
    rchk(arlc_pkg::OFF_STEP_LIMIT, 32'h00000000);
    // First result after reset has no predecessor, so only the second can step
    src_u.send(16'h0100, 1'b0);
    rchk(arlc_pkg::OFF_IRQ_STATUS, 32'h00000002);
    src_u.send(16'h0101, 1'b0);
    rchk(arlc_pkg::OFF_IRQ_STATUS, 32'h00000006);
    rchk(arlc_pkg::OFF_LAST_RESULT, 32'h00000101);
    finish_test();
  end
endmodule : testbench

bind arlc_top arlc_props chk_u (.aclk, .aresetn, .result_valid, .result_data, .result_is_temp, .conversion_valid,
  .conversion_result, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rready);
